// >>> hw/wwdt_pkg.sv
package wwdt_pkg;

   // register indices; byte address is four times the index
   localparam logic [2:0] IDX_CTRL = 3'h0;
   localparam logic [2:0] IDX_STATUS = 3'h1;
   localparam logic [2:0] IDX_KEY = 3'h2;
   localparam logic [2:0] IDX_CLEAR = 3'h3;
   localparam logic [2:0] IDX_LAST = 3'h3;
   localparam int ADDR_W = 5;
   localparam int ADDR_IDX_LSB = 2;

   // control register fields
   localparam int WIN_MSB = 7;
   localparam int WIN_LSB = 4;
   localparam int PER_MSB = 3;
   localparam int PER_LSB = 0;
   // status register fields
   localparam int LOCK_BIT = 7;
   localparam int SYNC_BIT = 0;

   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [3:0] CODE_OFF = 4'h0;
   localparam logic [3:0] CODE_MAX = 4'hB;
   localparam logic [13:0] BASE_CYCLES = 14'h0008;
   localparam logic [13:0] MAX_CYCLES = 14'h2000;

   // unlock key value is arbitrary
   localparam logic [7:0] UNLOCK_KEY = 8'hA5;
   localparam logic [2:0] KEY_WINDOW = 3'h4;

   // slow-clock ticks needed to carry a write or a clear across
   localparam logic [1:0] SYNC_TICKS = 2'h3;
   localparam logic [1:0] CLR_TICKS = 2'h3;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      PH_OFF = 2'b00,
      PH_NORMAL = 2'b01,
      PH_CLOSED = 2'b10,
      PH_OPEN = 2'b11
   } wwdt_phase_type;

   typedef struct packed {
      logic loaded;
      logic [7:0] ctrl;
      logic lock;
      logic [3:0] act_per;
      logic [3:0] act_win;
      logic sync_pend;
      logic [1:0] sync_cnt;
      logic clr_pend;
      logic [1:0] clr_cnt;
      wwdt_phase_type phase;
      logic [13:0] cnt;
      logic trip;
      logic [2:0] key_cnt;
      logic aw_have;
      logic [2:0] waddr;
      logic w_have;
      logic [7:0] wdata;
      logic wstb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
      logic clk_s1;
      logic clk_s2;
      logic clk_s3;
   } wwdt_state_type;

   function automatic logic [13:0] wwdt_decode(input logic [3:0] code);
      logic [13:0] len;
      len = 14'h0000;
      if (code == CODE_OFF) begin
         len = 14'h0000;
      end else if (code > CODE_MAX) begin
         len = MAX_CYCLES;
      end else begin
         len = 14'(BASE_CYCLES << (code - 4'h1));
      end
      return len;
   endfunction

endpackage

// >>> hw/wwdt_top.sv
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module wwdt_top
   import wwdt_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic WDT_CLK_I,
   input wire logic DEBUG_HALT_I,
   input wire logic [7:0] FUSE_CFG_I,
   input wire logic [ADDR_W-1:0] AWADDR_I,
   input wire logic AWVALID_I,
   output logic AWREADY_O,
   input wire logic [31:0] WDATA_I,
   input wire logic [3:0] WSTRB_I,
   input wire logic WVALID_I,
   output logic WREADY_O,
   output logic [1:0] BRESP_O,
   output logic BVALID_O,
   input wire logic BREADY_I,
   input wire logic [ADDR_W-1:0] ARADDR_I,
   input wire logic ARVALID_I,
   output logic ARREADY_O,
   output logic [31:0] RDATA_O,
   output logic [1:0] RRESP_O,
   output logic RVALID_O,
   input wire logic RREADY_I,
   output logic WDT_RESET_O
);

   wwdt_state_type st_ff;
   wwdt_state_type nxt_st;

   logic tick;
   logic [13:0] per_len;
   logic [13:0] win_len;
   logic [3:0] new_per;
   logic [3:0] new_win;
   logic [2:0] raddr;
   logic aw_hs;
   logic w_hs;
   logic ar_hs;
   logic do_wr;
   logic key_open;

   assign AWREADY_O = ~st_ff.aw_have & ~st_ff.bvalid;
   assign WREADY_O = ~st_ff.w_have & ~st_ff.bvalid;
   assign ARREADY_O = ~st_ff.rvalid;
   assign BVALID_O = st_ff.bvalid;
   assign BRESP_O = st_ff.bresp;
   assign RVALID_O = st_ff.rvalid;
   assign RRESP_O = st_ff.rresp;
   assign RDATA_O = {24'h000000, st_ff.rdata};
   assign WDT_RESET_O = st_ff.trip;

   assign aw_hs = AWVALID_I & AWREADY_O;
   assign w_hs = WVALID_I & WREADY_O;
   assign ar_hs = ARVALID_I & ARREADY_O;
   assign do_wr = st_ff.aw_have & st_ff.w_have & ~st_ff.bvalid;
   assign key_open = (st_ff.key_cnt != 3'h0);
   assign raddr = ARADDR_I[ADDR_IDX_LSB+2:ADDR_IDX_LSB];

   // the slow clock is sampled, never used as a clock, so the whole block stays in one domain
   assign tick = st_ff.clk_s2 & ~st_ff.clk_s3;
   assign per_len = wwdt_decode(st_ff.act_per);
   assign win_len = wwdt_decode(st_ff.act_win);
   assign new_per = st_ff.ctrl[PER_MSB:PER_LSB];
   assign new_win = st_ff.ctrl[WIN_MSB:WIN_LSB];

   always_comb begin
      nxt_st = st_ff;

      // slow clock edge detection
      nxt_st.clk_s1 = WDT_CLK_I;
      nxt_st.clk_s2 = st_ff.clk_s1;
      nxt_st.clk_s3 = st_ff.clk_s2;

      if (key_open) begin
         nxt_st.key_cnt = st_ff.key_cnt - 3'h1;
      end

      // configuration straps are caught on the first clock after reset release
      if (!st_ff.loaded) begin
         nxt_st.loaded = 1'b1;
         nxt_st.ctrl = FUSE_CFG_I;
         nxt_st.act_per = FUSE_CFG_I[PER_MSB:PER_LSB];
         nxt_st.act_win = FUSE_CFG_I[WIN_MSB:WIN_LSB];
         if (FUSE_CFG_I[PER_MSB:PER_LSB] != CODE_OFF) begin
            nxt_st.lock = 1'b1;
            nxt_st.phase = PH_NORMAL;
         end else begin
            nxt_st.phase = PH_OFF;
         end
      end else if (DEBUG_HALT_I) begin
         // halted: counter held at zero, resume runs one plain timeout
         nxt_st.cnt = 14'h0000;
         if (st_ff.phase != PH_OFF) begin
            nxt_st.phase = PH_NORMAL;
         end
      end else if (tick) begin
         if (st_ff.sync_pend) begin
            if (st_ff.sync_cnt == SYNC_TICKS - 2'h1) begin
               nxt_st.sync_pend = 1'b0;
               nxt_st.sync_cnt = 2'h0;
               nxt_st.act_per = new_per;
               nxt_st.act_win = new_win;
               if (new_per == CODE_OFF) begin
                  nxt_st.phase = PH_OFF;
                  nxt_st.cnt = 14'h0000;
               end else if (st_ff.act_per == CODE_OFF) begin
                  nxt_st.phase = PH_NORMAL;
                  nxt_st.cnt = 14'h0000;
               end else if (st_ff.act_win == CODE_OFF && new_win != CODE_OFF) begin
                  // freshly enabled window waits in plain mode for the first clear
                  nxt_st.phase = PH_NORMAL;
                  nxt_st.cnt = 14'h0000;
               end else if (new_win == CODE_OFF && st_ff.phase != PH_NORMAL) begin
                  nxt_st.phase = PH_NORMAL;
                  nxt_st.cnt = 14'h0000;
               end
            end else begin
               nxt_st.sync_cnt = st_ff.sync_cnt + 2'h1;
            end
         end

         if (st_ff.clr_pend && st_ff.clr_cnt == CLR_TICKS - 2'h1) begin
            // a clear reaching the slow side; the counting step is skipped this tick
            nxt_st.clr_pend = 1'b0;
            nxt_st.clr_cnt = 2'h0;
            unique case (st_ff.phase)
               PH_OFF: begin
                  nxt_st.cnt = 14'h0000;
               end
               PH_NORMAL: begin
                  nxt_st.cnt = 14'h0000;
                  if (st_ff.act_win != CODE_OFF) begin
                     nxt_st.phase = PH_CLOSED;
                  end
               end
               PH_CLOSED: begin
                  nxt_st.trip = 1'b1;
               end
               PH_OPEN: begin
                  nxt_st.cnt = 14'h0000;
                  nxt_st.phase = PH_CLOSED;
               end
            endcase
         end else begin
            if (st_ff.clr_pend) begin
               nxt_st.clr_cnt = st_ff.clr_cnt + 2'h1;
            end
            unique case (st_ff.phase)
               PH_OFF: begin
                  nxt_st.cnt = 14'h0000;
               end
               PH_NORMAL: begin
                  if (st_ff.cnt + 14'h0001 >= per_len) begin
                     nxt_st.trip = 1'b1;
                  end else begin
                     nxt_st.cnt = st_ff.cnt + 14'h0001;
                  end
               end
               PH_CLOSED: begin
                  if (st_ff.cnt + 14'h0001 >= win_len) begin
                     nxt_st.phase = PH_OPEN;
                     nxt_st.cnt = 14'h0000;
                  end else begin
                     nxt_st.cnt = st_ff.cnt + 14'h0001;
                  end
               end
               PH_OPEN: begin
                  if (st_ff.cnt + 14'h0001 >= per_len) begin
                     nxt_st.trip = 1'b1;
                  end else begin
                     nxt_st.cnt = st_ff.cnt + 14'h0001;
                  end
               end
            endcase
         end
      end

      // write channel: address and data taken in either order
      if (aw_hs) begin
         nxt_st.aw_have = 1'b1;
         nxt_st.waddr = AWADDR_I[ADDR_IDX_LSB+2:ADDR_IDX_LSB];
      end
      if (w_hs) begin
         nxt_st.w_have = 1'b1;
         nxt_st.wdata = WDATA_I[7:0];
         nxt_st.wstb = WSTRB_I[0];
      end
      if (st_ff.bvalid && BREADY_I) begin
         nxt_st.bvalid = 1'b0;
      end

      // bus writes come last so a set wins over a same-cycle clear
      if (do_wr) begin
         nxt_st.aw_have = 1'b0;
         nxt_st.w_have = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = (st_ff.waddr > IDX_LAST) ? RESP_SLVERR : RESP_OKAY;
         if (st_ff.wstb) begin
            unique case (st_ff.waddr)
               IDX_KEY: begin
                  if (st_ff.wdata == UNLOCK_KEY) begin
                     nxt_st.key_cnt = KEY_WINDOW;
                  end
               end
               IDX_CTRL: begin
                  nxt_st.key_cnt = 3'h0;
                  // no effect unless unlocked by key and not locked
                  if (key_open && !st_ff.lock && st_ff.loaded) begin
                     nxt_st.ctrl = st_ff.wdata;
                     nxt_st.sync_pend = 1'b1;
                     nxt_st.sync_cnt = 2'h0;
                  end
               end
               IDX_STATUS: begin
                  nxt_st.key_cnt = 3'h0;
                  if (key_open) begin
                     if (st_ff.wdata[LOCK_BIT]) begin
                        nxt_st.lock = 1'b1;
                     end else if (DEBUG_HALT_I) begin
                        nxt_st.lock = 1'b0;
                     end
                  end
               end
               IDX_CLEAR: begin
                  // a second clear rides on the one already in flight
                  nxt_st.clr_pend = 1'b1;
                  if (!st_ff.clr_pend || (tick && st_ff.clr_cnt == CLR_TICKS - 2'h1)) begin
                     nxt_st.clr_cnt = 2'h0;
                  end else begin
                     nxt_st.clr_cnt = nxt_st.clr_cnt;
                  end
               end
               default: begin
                  // reserved slot: the key window keeps running down
                  nxt_st.bresp = RESP_SLVERR;
               end
            endcase
         end
      end

      // read channel
      if (st_ff.rvalid && RREADY_I) begin
         nxt_st.rvalid = 1'b0;
      end
      if (ar_hs) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp = RESP_OKAY;
         nxt_st.rdata = 8'h00;
         unique case (raddr)
            IDX_CTRL: begin
               nxt_st.rdata = st_ff.ctrl;
            end
            IDX_STATUS: begin
               nxt_st.rdata[LOCK_BIT] = st_ff.lock;
               nxt_st.rdata[SYNC_BIT] = st_ff.sync_pend;
            end
            IDX_KEY, IDX_CLEAR: begin
               nxt_st.rdata = 8'h00;
            end
            default: begin
               nxt_st.rresp = RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         st_ff <= '{
            loaded: 1'b0,
            ctrl: CTRL_RST,
            lock: 1'b0,
            act_per: CODE_OFF,
            act_win: CODE_OFF,
            sync_pend: 1'b0,
            sync_cnt: 2'h0,
            clr_pend: 1'b0,
            clr_cnt: 2'h0,
            phase: PH_OFF,
            cnt: 14'h0000,
            trip: 1'b0,
            key_cnt: 3'h0,
            aw_have: 1'b0,
            waddr: 3'h0,
            w_have: 1'b0,
            wdata: 8'h00,
            wstb: 1'b0,
            bvalid: 1'b0,
            bresp: RESP_OKAY,
            rvalid: 1'b0,
            rdata: 8'h00,
            rresp: RESP_OKAY,
            clk_s1: 1'b0,
            clk_s2: 1'b0,
            clk_s3: 1'b0
         };
      end else begin
         st_ff <= nxt_st;
      end
   end

endmodule

`default_nettype wire

// >>> verif/windowed_watchdog_timer_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module windowed_watchdog_timer_tb_top;
   import wwdt_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wclk = 1'b0;
   logic halt = 1'b0;
   logic [7:0] fuse = 8'h01;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata, v;
   logic [1:0] bresp, rresp;
   logic awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid, trip;
   logic bready, rready;
   logic [31:0] seed = 32'h00002B5B;
   int fails = 0;
   int total_checks = 0;
   int m_ctrl, m_lock, m_pend;
   wwdt_top dut_u (.CLK_I(clk), .RST_I(rst), .WDT_CLK_I(wclk), .DEBUG_HALT_I(halt), .FUSE_CFG_I(fuse),
      .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(4'hF),
      .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
      .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp),
      .RVALID_O(rvalid), .RREADY_I(rready), .WDT_RESET_O(trip));
   wwdt_cpu_model cpu_u (.clk_i(clk), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
      .wdata_o(wdata), .wvalid_o(wvalid), .wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid),
      .bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata),
      .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));
   initial begin
      forever #10 clk = ~clk;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   // slow ticks kept 4 system cycles per half period so the synchroniser never misses one
   task automatic tick(input int n);
      repeat (n) begin
         wclk <= 1'b1;
         repeat (4) @(posedge clk);
         wclk <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask
   task automatic reboot(input logic [7:0] f);
      fuse <= f;
      rst <= 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      m_ctrl = f;
      m_lock = int'(f[3:0] != 4'h0);
      m_pend = 0;
   endtask
   task automatic w(input logic [2:0] idx, input logic [7:0] d, input logic [1:0] er);
      logic [1:0] r;
      // the key write is never held off, so the protected write still lands inside its window
      cpu_u.wr({idx, 2'b00}, d, (idx == IDX_KEY) ? 0 : int'(rnd() & 32'h00000003), r);
      chk(32'(r), 32'(er));
   endtask
   task automatic rs(input logic [2:0] idx, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      cpu_u.rd({idx, 2'b00}, int'(rnd() & 32'h00000003), d, r);
      chk(32'(r), 32'(er));
      if (idx == IDX_CTRL) begin
         chk(d, 32'(m_ctrl));
      end else if (er == RESP_OKAY) begin
         chk(d, 32'(m_lock * 128 + m_pend));
      end
   endtask
   task automatic cw(input bit key, input logic [2:0] idx, input logic [7:0] d);
      if (key) begin
         w(IDX_KEY, UNLOCK_KEY, RESP_OKAY);
      end
      w(idx, d, RESP_OKAY);
      if (key && idx == IDX_CTRL && m_lock == 0) begin
         m_ctrl = d;
         m_pend = 1;
      end
      if (key && idx == IDX_STATUS && (d[7] || halt)) begin
         m_lock = int'(d[7]);
      end
   endtask
   initial begin
      @(posedge clk);
      reboot(8'h01);
      rs(IDX_CTRL, RESP_OKAY);
      rs(IDX_STATUS, RESP_OKAY);
      cw(1'b1, IDX_CTRL, 8'h00);
      rs(IDX_CTRL, RESP_OKAY);
      tick(3);
      w(IDX_CLEAR, 8'(rnd()), RESP_OKAY);
      tick(1);
      w(IDX_CLEAR, 8'(rnd()), RESP_OKAY);
      tick(8);
      chk(32'(trip), 32'h0);
      tick(1);
      chk(32'(trip), 32'h0);
      tick(1);
      chk(32'(trip), 32'h1);
      reboot(8'h00);
      rs(IDX_STATUS, RESP_OKAY);
      cw(1'b0, IDX_CTRL, 8'h21);
      rs(IDX_CTRL, RESP_OKAY);
      tick(20);
      chk(32'(trip), 32'h0);
      cw(1'b1, IDX_CTRL, 8'h21);
      rs(IDX_STATUS, RESP_OKAY);
      tick(4);
      m_pend = 0;
      rs(IDX_STATUS, RESP_OKAY);
      rs(IDX_CTRL, RESP_OKAY);
      v = rnd();
      w({1'b1, v[1:0]}, v[15:8], RESP_SLVERR);
      rs({1'b1, v[3:2]}, RESP_SLVERR);
      w(IDX_CLEAR, v[7:0], RESP_OKAY);
      tick(20);
      chk(32'(trip), 32'h0);
      w(IDX_CLEAR, 8'(rnd()), RESP_OKAY);
      tick(10);
      chk(32'(trip), 32'h0);
      w(IDX_CLEAR, 8'(rnd()), RESP_OKAY);
      tick(4);
      chk(32'(trip), 32'h1);
      reboot(8'h00);
      cw(1'b1, IDX_STATUS, 8'h80);
      cw(1'b1, IDX_CTRL, 8'h21);
      rs(IDX_CTRL, RESP_OKAY);
      cw(1'b1, IDX_STATUS, 8'h00);
      rs(IDX_STATUS, RESP_OKAY);
      halt <= 1'b1;
      cw(1'b1, IDX_STATUS, 8'h00);
      halt <= 1'b0;
      rs(IDX_STATUS, RESP_OKAY);
      cw(1'b1, IDX_CTRL, 8'h21);
      tick(4);
      m_pend = 0;
      halt <= 1'b1;
      tick(20);
      chk(32'(trip), 32'h0);
      halt <= 1'b0;
      tick(7);
      chk(32'(trip), 32'h0);
      tick(1);
      chk(32'(trip), 32'h1);
      test_done();
   end
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      test_done();
   end
endmodule
`default_nettype wire

// >>> verif/wwdt_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module wwdt_assertions
   import wwdt_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic AWVALID_I,
   input wire logic AWREADY_O,
   input wire logic WVALID_I,
   input wire logic WREADY_O,
   input wire logic [1:0] BRESP_O,
   input wire logic BVALID_O,
   input wire logic BREADY_I,
   input wire logic [ADDR_W-1:0] ARADDR_I,
   input wire logic ARVALID_I,
   input wire logic ARREADY_O,
   input wire logic [31:0] RDATA_O,
   input wire logic [1:0] RRESP_O,
   input wire logic RVALID_O,
   input wire logic RREADY_I,
   input wire logic WDT_RESET_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   sequence both_taken;
      AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
   endsequence
   sequence ar_taken;
      ARVALID_I && ARREADY_O;
   endsequence
   sequence resp_pending;
      !BVALID_O ##1 BVALID_O;
   endsequence
   write_answer_a: assert property (both_taken |=> resp_pending) else $error("write answer mistimed");
   bresp_hold_a: assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O)) else $error("write answer dropped");
   read_answer_a: assert property (ar_taken |=> RVALID_O) else $error("read answer late");
   read_hold_a: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O) && $stable(RRESP_O))
      else $error("read answer dropped");
   read_err_a: assert property (ARVALID_I && ARREADY_O && ARADDR_I[ADDR_W-1:ADDR_IDX_LSB] > IDX_LAST
      |=> RRESP_O == RESP_SLVERR) else $error("reserved read not refused");
   read_upper_a: assert property (RVALID_O |-> RDATA_O[31:8] == 24'h000000) else $error("upper read bits set");
   write_block_a: assert property (BVALID_O |-> !AWREADY_O && !WREADY_O) else $error("write taken during answer");
   read_block_a: assert property (RVALID_O |-> !ARREADY_O) else $error("read taken during answer");
   trip_sticky_a: assert property (WDT_RESET_O |=> WDT_RESET_O[*8]) else $error("reset request fell");
endmodule
bind wwdt_top wwdt_assertions chk_u (.CLK_I, .RST_I, .AWVALID_I, .AWREADY_O, .WVALID_I, .WREADY_O, .BRESP_O,
   .BVALID_O, .BREADY_I, .ARADDR_I, .ARVALID_I, .ARREADY_O, .RDATA_O, .RRESP_O, .RVALID_O, .RREADY_I, .WDT_RESET_O);
`default_nettype wire

// >>> verif/wwdt_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module wwdt_cpu_model
   import wwdt_pkg::*;
(
   input wire logic clk_i,
   output logic [ADDR_W-1:0] awaddr_o,
   output logic awvalid_o,
   input wire logic awready_i,
   output logic [31:0] wdata_o,
   output logic wvalid_o,
   input wire logic wready_i,
   input wire logic [1:0] bresp_i,
   input wire logic bvalid_i,
   output logic bready_o,
   output logic [ADDR_W-1:0] araddr_o,
   output logic arvalid_o,
   input wire logic arready_i,
   input wire logic [31:0] rdata_i,
   input wire logic [1:0] rresp_i,
   input wire logic rvalid_i,
   output logic rready_o
);
   initial begin
      awaddr_o = '0;
      awvalid_o = 1'b0;
      wdata_o = '0;
      wvalid_o = 1'b0;
      araddr_o = '0;
      arvalid_o = 1'b0;
      bready_o = 1'b1;
      rready_o = 1'b1;
   end
   // ready is sampled at the falling edge: nothing moves before the next rising edge
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input int hold, output logic [1:0] r);
      logic pa, pw, ta, tw, bv;
      int n;
      pa = 1'b1;
      pw = 1'b1;
      bv = 1'b0;
      n = 0;
      awaddr_o <= a;
      wdata_o <= {24'h000000, d};
      awvalid_o <= 1'b1;
      wvalid_o <= 1'b1;
      // a held-off accept makes the answer stand for a few cycles
      bready_o <= (hold == 0);
      while (!bv) begin
         @(negedge clk_i);
         ta = pa & awready_i;
         tw = pw & wready_i;
         bv = bvalid_i & bready_o;
         r = bresp_i;
         @(posedge clk_i);
         n++;
         if (n == hold) begin
            bready_o <= 1'b1;
         end
         if (ta) begin
            awvalid_o <= 1'b0;
            awaddr_o <= ~a;
            pa = 1'b0;
         end
         if (tw) begin
            wvalid_o <= 1'b0;
            wdata_o <= ~{24'h000000, d};
            pw = 1'b0;
         end
      end
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input int hold, output logic [31:0] d, output logic [1:0] r);
      logic pa, ta, rv;
      int n;
      pa = 1'b1;
      rv = 1'b0;
      n = 0;
      araddr_o <= a;
      arvalid_o <= 1'b1;
      rready_o <= (hold == 0);
      while (!rv) begin
         @(negedge clk_i);
         ta = pa & arready_i;
         rv = rvalid_i & rready_o;
         d = rdata_i;
         r = rresp_i;
         @(posedge clk_i);
         n++;
         if (n == hold) begin
            rready_o <= 1'b1;
         end
         if (ta) begin
            arvalid_o <= 1'b0;
            araddr_o <= ~a;
            pa = 1'b0;
         end
      end
   endtask
endmodule
`default_nettype wire
